// ==== verilog/ecl_config_loader.sv ====
// Overview of operation
// - Mode 01 drives legacy lines plus PCI lines
// - Mode 10 legacy serial, PCI on parallel lines
// - Mode 11 everything on serial IRQ line
// - Mode 00 only PCI interrupt lines
// - Tie bit merges both PCI interrupts onto A
// - Strap low at reset release sets detect, loads
// - Detect set: pins one/four become data/clock
// - EEPROM addressed at seven-bit address 1010000
// - Clearing detect restores routed pin functions
// - Bytes 02-05 load subsystem vendor and id
// - Byte 01 bit 7 to command bit 8
// - Byte 13 loads device control register
// - Release bus after latency timer when requested
// - Card grant held until transaction ends
// - Subsystem ids writable only while lock clear
// - Routing register picks each multifunction pin role
// - Capability bit 4 mirrors bit 15
// - Power event enable at control bit 8
// - Card control enables ring and speaker outputs
// - Legacy register routes status change to PCI
`timescale 1ns/1ps
`default_nettype none
module ecl_config_loader
	import ecl_pkg::*;
(
	input  wire logic        clk,                       // PCI clock
	input  wire logic        arst_n,                    // Global reset
	input  wire logic        latch_strap,               // EEPROM strap, low = present
	input  wire ecl_cfg_req_type cfg,                   // Config access
	output logic [31:0]      cfg_rdata,                 // Read data
	output logic             cfg_ack,                   // Access accepted pulse
	input  wire logic [15:0] legacy_irq_req,            // Legacy requests 15:0
	input  wire logic        pci_irq_a_req,             // Function A request
	input  wire logic        pci_irq_b_req,             // Function B request
	input  wire logic        card_status_change,        // Card status change event
	input  wire logic        ring_in,                   // Ring from card
	input  wire logic        speaker_in,                // Speaker from card
	input  wire logic        other_req,                 // Another master requests
	input  wire logic        bus_owned,                 // Bridge owns PCI bus
	input  wire logic        card_req,                  // Card requests card bus
	input  wire logic        card_xfer_active,          // Card transaction ongoing
	input  wire logic        pin_one_in,                // Pin one level in
	output logic             bus_release,               // Give up PCI bus
	output logic             card_grant_n,              // Card bus grant
	output logic             pci_interrupt_line_a_n,    // PCI line A
	output logic             pci_interrupt_line_b_n,    // PCI line B
	output logic [15:0]      parallel_legacy_irq_lines, // Legacy lines 15:2 used
	output logic             serialized_irq_line,       // Serial IRQ slot data
	output logic             ring_indicate_output_n,    // Ring out
	output logic             speaker_output,            // Speaker out
	output logic             multifunction_pin_one,     // Pin one value
	output logic             multifunction_pin_one_oe_n,// Pin one enable low
	output logic             multifunction_pin_four,    // Pin four value
	output logic             multifunction_pin_four_oe_n,// Pin four enable low
	output logic [6:0]       pin_role_active,           // Pin uses routed role
	output logic             load_busy                  // EEPROM load running
);
	typedef struct packed {
		logic [15:0] command;
		logic [7:0]  cache_line;
		logic [7:0]  bus_lat;
		logic [7:0]  cb_lat;
		logic [15:0] subsystem_vendor_code;
		logic [15:0] subsystem_code;
		logic [31:0] sysctl;
		logic [31:0] route;
		logic [7:0]  cardctl;
		logic [7:0]  devctl;
		logic        pme_cold;
		logic        pme_en;
		logic        detect;
		logic [7:0]  legacy_int;
		logic        loading;
		logic        strapped;
		logic [7:0]  idx;
		logic        go;
		logic        next;
		logic [7:0]  lat_cnt;
		logic        release_q;
		logic        grant_n;
		logic        ack;
		logic [31:0] rdata;
		logic        ia_n;
		logic        ib_n;
		logic [15:0] lirq;
		logic        sirq;
		logic        ring_n;
		logic        spkr;
		logic        p1;
		logic        p1_oe_n;
		logic        p4;
		logic        p4_oe_n;
		logic [6:0]  role;
	} ecl_top_type;
	ecl_top_type s_r, s_nxt;
	ecl_ser_rsp_type ser_rsp;
	logic sda_oe_n, scl_oe_n;
	logic pa, pb, csc_pci;

	// Byte lane select for writes
	function automatic logic [7:0] lane(input logic [31:0] d, input logic [1:0] n);
		lane = d[8*n +: 8];
	endfunction

	////////////////////////////////////////////////////////////////
	// Serial reader
	ecl_twi_reader u_twi (
		.clk      (clk),
		.arst_n   (arst_n),
		.go       (s_r.go),
		.next     (s_r.next),
		.last     (s_r.idx == EEPROM_LAST),
		.sda_in   (pin_one_in),
		.sda_oe_n (sda_oe_n),
		.scl_oe_n (scl_oe_n),
		.rsp      (ser_rsp)
	);

	////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.go = 1'b0;
		s_nxt.next = 1'b0;
		s_nxt.ack = 1'b0;
		// Strap sampled on first clock after reset release
		// strap detect load
		if (!s_r.strapped) begin
			s_nxt.strapped = 1'b1;
			if (!latch_strap) begin
				s_nxt.detect = 1'b1;
				s_nxt.loading = 1'b1;
				s_nxt.go = 1'b1;
			end
		end
		if (s_r.loading && ser_rsp.done) begin
			s_nxt.idx = s_r.idx + 8'h01;
			s_nxt.next = (s_r.idx != EEPROM_LAST);
			if (s_r.idx == EEPROM_LAST || ser_rsp.nack)
				s_nxt.loading = 1'b0;
			case (s_r.idx)
				8'h01: begin
					s_nxt.command[BIT_CMD_HI] = ser_rsp.data[7];
					s_nxt.command[6:5] = ser_rsp.data[6:5];
					s_nxt.command[2:0] = ser_rsp.data[2:0];
				end
				8'h02: s_nxt.subsystem_vendor_code[7:0]  = ser_rsp.data;
				8'h03: s_nxt.subsystem_vendor_code[15:8] = ser_rsp.data;
				8'h04: s_nxt.subsystem_code[7:0]   = ser_rsp.data;
				8'h05: s_nxt.subsystem_code[15:8]  = ser_rsp.data;
				8'h0A: s_nxt.sysctl[7:0] = ser_rsp.data;
				8'h0B: s_nxt.sysctl[15:8] = ser_rsp.data;
				8'h0C: s_nxt.sysctl[31:24] = ser_rsp.data;
				8'h0D: s_nxt.route[7:0]  = ser_rsp.data;
				8'h0E: s_nxt.route[15:8] = ser_rsp.data;
				8'h0F: s_nxt.route[23:16] = ser_rsp.data;
				8'h10: s_nxt.route[31:24] = ser_rsp.data;
				8'h12: s_nxt.cardctl = ser_rsp.data;
				8'h13: begin
					s_nxt.devctl[6] = ser_rsp.data[6];
					s_nxt.devctl[3:0] = ser_rsp.data[3:0];
				end
				8'h15: s_nxt.pme_cold = ser_rsp.data[7];
				default: ;
			endcase
		end
		// Config writes, held off while loading
		if (cfg.wr && !s_r.loading) begin
			s_nxt.ack = 1'b1;
			case (cfg.addr)
				OFS_COMMAND: begin
					if (cfg.be[0]) s_nxt.command[7:0] = lane(cfg.wdata, 2'h0);
					if (cfg.be[1]) s_nxt.command[15:8] = lane(cfg.wdata, 2'h1);
				end
				OFS_CACHE_LINE: if (cfg.be[0]) s_nxt.cache_line = lane(cfg.wdata, 2'h0);
				OFS_BUS_LAT:    if (cfg.be[0]) s_nxt.bus_lat = lane(cfg.wdata, 2'h0);
				OFS_CB_LAT:     if (cfg.be[0]) s_nxt.cb_lat = lane(cfg.wdata, 2'h0);
				OFS_SUBSYS_VEN: if (!s_r.sysctl[BIT_WRITE_LOCK]) begin
					if (cfg.be[0]) s_nxt.subsystem_vendor_code[7:0] = lane(cfg.wdata, 2'h0);
					if (cfg.be[1]) s_nxt.subsystem_vendor_code[15:8] = lane(cfg.wdata, 2'h1);
				end
				OFS_SUBSYS: if (!s_r.sysctl[BIT_WRITE_LOCK]) begin
					if (cfg.be[0]) s_nxt.subsystem_code[7:0] = lane(cfg.wdata, 2'h0);
					if (cfg.be[1]) s_nxt.subsystem_code[15:8] = lane(cfg.wdata, 2'h1);
				end
				OFS_SYS_CTRL:  s_nxt.sysctl = cfg.wdata;
				OFS_PIN_ROUTE: s_nxt.route = cfg.wdata;
				OFS_CARD_CTRL: if (cfg.be[0]) s_nxt.cardctl = lane(cfg.wdata, 2'h0);
				OFS_DEV_CTRL:  if (cfg.be[0]) s_nxt.devctl = lane(cfg.wdata, 2'h0);
				OFS_PM_CAP:    if (cfg.be[1]) s_nxt.pme_cold = cfg.wdata[BIT_PME_COLD];
				OFS_PM_CSR:    if (cfg.be[1]) s_nxt.pme_en = cfg.wdata[BIT_PME_EN];
				OFS_SER_CTRL:  if (cfg.be[0] && !cfg.wdata[BIT_SER_DETECT])
					s_nxt.detect = 1'b0;
				OFS_LEGACY_INT: if (cfg.be[0]) s_nxt.legacy_int = lane(cfg.wdata, 2'h0);
				default: ;
			endcase
		end
		// Config reads
		if (cfg.rd && !s_r.loading) begin
			s_nxt.ack = 1'b1;
			case (cfg.addr)
				OFS_COMMAND:    s_nxt.rdata = {16'h0000, s_r.command};
				OFS_CACHE_LINE: s_nxt.rdata = {24'h000000, s_r.cache_line};
				OFS_BUS_LAT:    s_nxt.rdata = {24'h000000, s_r.bus_lat};
				OFS_CB_LAT:     s_nxt.rdata = {24'h000000, s_r.cb_lat};
				OFS_SUBSYS_VEN: s_nxt.rdata = {16'h0000, s_r.subsystem_vendor_code};
				OFS_SUBSYS:     s_nxt.rdata = {16'h0000, s_r.subsystem_code};
				OFS_SYS_CTRL:   s_nxt.rdata = s_r.sysctl;
				OFS_PIN_ROUTE:  s_nxt.rdata = s_r.route;
				OFS_CARD_CTRL:  s_nxt.rdata = {24'h000000, s_r.cardctl};
				OFS_DEV_CTRL:   s_nxt.rdata = {24'h000000, s_r.devctl};
				OFS_PM_CAP: s_nxt.rdata = {16'h0000, s_r.pme_cold, 10'h000, s_r.pme_cold, 4'h0};
				OFS_PM_CSR:     s_nxt.rdata = {23'h000000, s_r.pme_en, 8'h00};
				OFS_SER_CTRL:   s_nxt.rdata = {28'h0000000, s_r.detect, 3'h0};
				OFS_LEGACY_INT: s_nxt.rdata = {24'h000000, s_r.legacy_int};
				default:        s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (bus_owned && other_req) begin
			if (s_r.lat_cnt != 8'hFF)
				s_nxt.lat_cnt = s_r.lat_cnt + 8'h01;
		end else begin
			s_nxt.lat_cnt = 8'h00;
		end
		s_nxt.release_q = bus_owned && other_req && (s_r.lat_cnt >= s_r.bus_lat);
		if (s_r.grant_n)
			s_nxt.grant_n = !card_req;
		else
			s_nxt.grant_n = !(card_req || card_xfer_active);
		s_nxt.ia_n = !(pa && s_r.devctl[2:1] != IMODE_SER_ALL);
		s_nxt.ib_n = !(pb && s_r.devctl[2:1] != IMODE_SER_ALL);
		s_nxt.lirq = (s_r.devctl[2:1] == IMODE_PAR_ALL) ? {legacy_irq_req[15:2], 2'h0} : 16'h0000;
		case (s_r.devctl[2:1])
			IMODE_SER_PCI: s_nxt.sirq = |legacy_irq_req[15:2];
			IMODE_SER_ALL: s_nxt.sirq = (|legacy_irq_req[15:2]) | pa | pb;
			default:       s_nxt.sirq = 1'b0;
		endcase
		s_nxt.ring_n = !(ring_in && s_r.cardctl[BIT_RING_EN]);
		s_nxt.spkr = speaker_in && s_r.cardctl[BIT_SPKR_EN];
		s_nxt.p1 = 1'b0;
		s_nxt.p4 = 1'b0;
		if (s_r.detect) begin
			s_nxt.p1_oe_n = sda_oe_n;
			s_nxt.p4_oe_n = scl_oe_n;
		end else begin
			s_nxt.p1 = !s_nxt.ib_n ? 1'b0 : 1'b1;
			s_nxt.p1_oe_n = !(s_r.route[7:4] != 4'h0 && !s_nxt.ib_n);
			s_nxt.p4_oe_n = 1'b1;
		end
		for (int i = 0; i < 7; i++)
			s_nxt.role[i] = (s_r.route[4*i +: 4] != 4'h0);
		if (s_r.detect) begin
			s_nxt.role[1] = 1'b0;
			s_nxt.role[4] = 1'b0;
		end
	end

	// Interrupt sources with tie and status-change routing
	// tie merges B onto A
	assign csc_pci = card_status_change && s_r.legacy_int[BIT_CSC_ROUTE];
	assign pa = pci_irq_a_req || csc_pci || (s_r.sysctl[BIT_INT_TIE] && pci_irq_b_req);
	assign pb = pci_irq_b_req && !s_r.sysctl[BIT_INT_TIE];

	////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{sysctl: SYS_CTRL_RST, route: ROUTE_RST, grant_n: 1'b1, ia_n: 1'b1,
				ib_n: 1'b1, ring_n: 1'b1, p1_oe_n: 1'b1, p4_oe_n: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// mode 00 only PCI lines drive
	assign cfg_rdata                   = s_r.rdata;
	assign cfg_ack                     = s_r.ack;
	assign bus_release                 = s_r.release_q;
	assign card_grant_n                = s_r.grant_n;
	assign pci_interrupt_line_a_n      = s_r.ia_n;
	assign pci_interrupt_line_b_n      = s_r.ib_n;
	assign parallel_legacy_irq_lines   = s_r.lirq;
	assign serialized_irq_line         = s_r.sirq;
	assign ring_indicate_output_n      = s_r.ring_n;
	assign speaker_output              = s_r.spkr;
	assign multifunction_pin_one       = s_r.p1;
	assign multifunction_pin_one_oe_n  = s_r.p1_oe_n;
	assign multifunction_pin_four      = s_r.p4;
	assign multifunction_pin_four_oe_n = s_r.p4_oe_n;
	assign pin_role_active             = s_r.role;
	assign load_busy                   = s_r.loading;

	////////////////////////////////////////////////////////////////
	// Checks
	AST_MODE00: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.devctl[2:1] == IMODE_PCI_ONLY) |=> (s_r.lirq == 16'h0000 && !s_r.sirq))
		else $error("mode 00 drove legacy");
	AST_MODE01: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.devctl[2:1] == IMODE_PAR_ALL) |=> (s_r.lirq[15:2] == $past(legacy_irq_req[15:2])))
		else $error("mode 01 lines wrong");
	AST_MODE10: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.devctl[2:1] == IMODE_SER_PCI && pci_irq_a_req) |=> !s_r.ia_n)
		else $error("mode 10 line A idle");
	AST_MODE11: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.devctl[2:1] == IMODE_SER_ALL && $stable(s_r.devctl)) |=> (s_r.ia_n && s_r.ib_n))
		else $error("mode 11 drove PCI line");
	AST_TIE: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.sysctl[BIT_INT_TIE] && pci_irq_b_req && s_r.devctl[2:1] != IMODE_SER_ALL)
		|=> (!s_r.ia_n && s_r.ib_n)) else $error("tie not merging");
	AST_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.wr && cfg.addr == OFS_SUBSYS && s_r.sysctl[BIT_WRITE_LOCK] && !s_r.loading)
		|=> $stable(s_r.subsystem_code)) else $error("locked id written");
	AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.loading && cfg.wr) |=> !s_r.ack) else $error("write during load");
	AST_GRANT: assert property (@(posedge clk) disable iff (!arst_n)
		(!s_r.grant_n && card_xfer_active) |=> !s_r.grant_n) else $error("grant dropped");
	AST_LAT: assert property (@(posedge clk) disable iff (!arst_n)
		(bus_owned && other_req && s_r.lat_cnt < s_r.bus_lat) |=> !s_r.release_q)
		else $error("early release");
	AST_PINS: assert property (@(posedge clk) disable iff (!arst_n)
		s_r.detect |=> (s_r.p4_oe_n == $past(scl_oe_n))) else $error("clock pin not borrowed");
endmodule
`default_nettype wire

// ==== verilog/ecl_pkg.sv ====
package ecl_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CACHE_LINE   = 8'h0C;
	localparam logic [7:0] OFS_BUS_LAT      = 8'h0D;
	localparam logic [7:0] OFS_COMMAND      = 8'h04;
	localparam logic [7:0] OFS_CB_LAT       = 8'h1B;
	localparam logic [7:0] OFS_SUBSYS_VEN   = 8'h40;
	localparam logic [7:0] OFS_SUBSYS       = 8'h42;
	localparam logic [7:0] OFS_SYS_CTRL     = 8'h80;
	localparam logic [7:0] OFS_PIN_ROUTE    = 8'h8C;
	localparam logic [7:0] OFS_CARD_CTRL    = 8'h91;
	localparam logic [7:0] OFS_DEV_CTRL     = 8'h92;
	localparam logic [7:0] OFS_PM_CAP       = 8'hA2;
	localparam logic [7:0] OFS_PM_CSR       = 8'hA4;
	localparam logic [7:0] OFS_SER_CTRL     = 8'hB3;
	localparam logic [7:0] OFS_LEGACY_INT   = 8'hC3;
	// Field positions
	localparam int BIT_WRITE_LOCK  = 5;
	localparam int BIT_INT_TIE     = 29;
	localparam int BIT_SER_DETECT  = 3;
	localparam int BIT_PME_EN      = 8;
	localparam int BIT_PME_COLD    = 15;
	localparam int BIT_PME_AUX     = 4;
	localparam int BIT_RING_EN     = 7;
	localparam int BIT_SPKR_EN     = 1;
	localparam int BIT_CSC_ROUTE   = 4;
	localparam int BIT_CMD_HI      = 8;
	// Interrupt modes
	localparam logic [1:0] IMODE_PCI_ONLY  = 2'h0;
	localparam logic [1:0] IMODE_PAR_ALL   = 2'h1;
	localparam logic [1:0] IMODE_SER_PCI   = 2'h2;
	localparam logic [1:0] IMODE_SER_ALL   = 2'h3;
	// Serial bus constants
	localparam logic [6:0] EEPROM_ADDR     = 7'h50;
	localparam logic [7:0] EEPROM_LAST     = 8'h15;
	localparam logic [7:0] SCL_HALF        = 8'h3F;
	// Reset values
	localparam logic [31:0] SYS_CTRL_RST   = 32'h0000_0020;
	localparam logic [31:0] ROUTE_RST      = 32'h0000_0000;
	// Config access carrier
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} ecl_cfg_req_type;
	// Serial byte-read interface
	typedef struct packed {
		logic       done;
		logic       nack;
		logic [7:0] data;
	} ecl_ser_rsp_type;
	typedef enum logic [3:0] {
		SS_IDLE  = 4'h0,
		SS_START = 4'h1,
		SS_BYTE  = 4'h2,
		SS_ACK   = 4'h3,
		SS_RSTRT = 4'h4,
		SS_RDB   = 4'h5,
		SS_MACK  = 4'h6,
		SS_STOP  = 4'h7,
		SS_DONE  = 4'h8
	} ecl_ser_state_type;
endpackage

// ==== verilog/ecl_twi_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecl_twi_reader
	import ecl_pkg::*;
(
	input  wire logic        clk,       // Clock
	input  wire logic        arst_n,    // Reset
	input  wire logic        go,        // Start sequential read
	input  wire logic        next,      // Request next byte
	input  wire logic        last,      // This byte is final
	input  wire logic        sda_in,    // Data line level
	output logic             sda_oe_n,  // Data pull low when 0
	output logic             scl_oe_n,  // Clock pull low when 0
	output ecl_ser_rsp_type  rsp        // Byte answer
);
	typedef struct packed {
		ecl_ser_state_type st;
		logic [7:0]        tick;
		logic [1:0]        ph;
		logic [3:0]        bitn;
		logic [7:0]        sh;
		logic [1:0]        hdr;
		logic              sda;
		logic              scl;
		ecl_ser_rsp_type   rsp;
	} ecl_twi_type;
	ecl_twi_type s_r, s_nxt;
	logic stp;
	assign stp = (s_r.tick == SCL_HALF);

	////////////////////////////////////////////////////////////////
	// Bit sequencer, four phases per bit
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp.done = 1'b0;
		s_nxt.tick = stp ? 8'h00 : s_r.tick + 8'h01;
		if (s_r.st == SS_IDLE)
			s_nxt.tick = 8'h00;
		case (s_r.st)
			SS_IDLE: begin
				s_nxt.scl = 1'b1;
				s_nxt.sda = 1'b1;
				if (go) begin
					s_nxt.st = SS_START;
					s_nxt.hdr = 2'h0;
					s_nxt.ph = 2'h0;
				end
			end
			SS_START, SS_RSTRT: if (stp) begin
				s_nxt.ph = s_r.ph + 2'h1;
				case (s_r.ph)
					2'h0: begin s_nxt.sda = 1'b1; s_nxt.scl = 1'b1; end
					2'h1: s_nxt.sda = 1'b0;
					2'h2: s_nxt.scl = 1'b0;
					default: begin
						s_nxt.st = SS_BYTE;
						s_nxt.bitn = 4'h0;
						s_nxt.ph = 2'h0;
						// Write header first, read header after restart
						s_nxt.sh = {EEPROM_ADDR, (s_r.st == SS_RSTRT)};
					end
				endcase
			end
			SS_BYTE, SS_RDB, SS_ACK, SS_MACK: if (stp) begin
				s_nxt.ph = s_r.ph + 2'h1;
				case (s_r.ph)
					2'h0: s_nxt.sda = (s_r.st == SS_BYTE) ? s_r.sh[7] :
						(s_r.st == SS_MACK) ? last : 1'b1;
					2'h1: s_nxt.scl = 1'b1;
					2'h2: begin
						if (s_r.st == SS_RDB)
							s_nxt.sh = {s_r.sh[6:0], sda_in};
						if (s_r.st == SS_ACK && sda_in)
							s_nxt.rsp.nack = 1'b1;
					end
					default: begin
						s_nxt.scl = 1'b0;
						s_nxt.bitn = s_r.bitn + 4'h1;
						if (s_r.st == SS_BYTE)
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
						if ((s_r.st == SS_BYTE || s_r.st == SS_RDB) && s_r.bitn == 4'h7) begin
							s_nxt.st = (s_r.st == SS_BYTE) ? SS_ACK : SS_MACK;
							if (s_r.st == SS_RDB)
								s_nxt.rsp.data = s_r.sh;
						end else if (s_r.st == SS_ACK) begin
							s_nxt.bitn = 4'h0;
							s_nxt.hdr = s_r.hdr + 2'h1;
							// Header, word address 00, restart, then data
							case (s_r.hdr)
								2'h0: begin s_nxt.st = SS_BYTE; s_nxt.sh = 8'h00; end
								2'h1: s_nxt.st = SS_RSTRT;
								default: s_nxt.st = SS_RDB;
							endcase
						end else if (s_r.st == SS_MACK) begin
							s_nxt.rsp.done = 1'b1;
							s_nxt.bitn = 4'h0;
							s_nxt.st = last ? SS_STOP : SS_DONE;
						end
					end
				endcase
			end
			SS_DONE: begin
				s_nxt.tick = 8'h00;
				if (next)
					s_nxt.st = SS_RDB;
			end
			SS_STOP: if (stp) begin
				s_nxt.ph = s_r.ph + 2'h1;
				case (s_r.ph)
					2'h0: s_nxt.sda = 1'b0;
					2'h1: s_nxt.scl = 1'b1;
					2'h2: s_nxt.sda = 1'b1;
					default: s_nxt.st = SS_IDLE;
				endcase
			end
			default: s_nxt.st = SS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{st: SS_IDLE, sda: 1'b1, scl: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign sda_oe_n = s_r.sda;
	assign scl_oe_n = s_r.scl;
	assign rsp      = s_r.rsp;

	// Header byte carries the fixed slave address
	AST_HDR_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
		(s_r.st != SS_BYTE && s_nxt.st == SS_BYTE && s_r.st != SS_ACK) |=>
		(s_r.sh[7:1] == EEPROM_ADDR)) else $error("wrong slave address");
endmodule
`default_nettype wire

// ==== verification/ecl_eeprom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecl_eeprom_model (
	input  wire logic scl,      // Clock wire
	input  wire logic sda,      // Data wire
	output logic      sda_pull  // Pull data low
);
	logic [7:0] mem [0:255];
	logic [7:0] sh, cur, ptr;
	int         b, st;
	logic       act, rd;
	initial begin
		sda_pull = 1'b0;
		act = 1'b0;
		ptr = 8'h00;
	end
	// Start opens a frame, stop closes it
	always @(sda) if (scl) begin
		act = !sda;
		b = 0;
		st = 0;
		rd = 1'b0;
	end
	// Shift in bits, master NACK ends a read
	always @(posedge scl) if (act) begin
		if (b < 8) sh = {sh[6:0], sda};
		else if (rd && sda) act = 1'b0;
		b = (b + 1) % 9;
	end
	// Drive acknowledge and read data while clock is low
	always @(negedge scl) if (act) begin
		sda_pull = 1'b0;
		if (b == 8 && !rd) begin
			if (st == 1) ptr = sh;
			else if (sh[7:1] != 7'h50) act = 1'b0;
			rd = (st == 0) && sh[0];
			sda_pull = act;
			st = st + 1;
		end else if (b < 8 && rd) begin
			if (b == 0) begin
				cur = mem[ptr];
				ptr = ptr + 8'h01;
			end
			sda_pull = !cur[7 - b];
		end
	end
endmodule
`default_nettype wire

// ==== verification/ecl_config_loader_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecl_config_loader_test import ecl_pkg::*;;
	logic            clk, arst_n, ack, ia, ib, busy, pa_n, pb_n, ser, pull, p1, p1_oe_n, p4, p4_oe_n;
	logic            rel, gnt_n, ring_n, spk;
	logic [6:0]      misc;
	logic [15:0]     lreq, lout;
	logic [31:0]     rdata, r, q_e[$], q_m[$];
	logic [7:0]      ee [0:21];
	ecl_cfg_req_type cfg;
	int              errors, check_count, i, t;
	// Open-drain wires with pull-ups
	wire logic sda_w = (p1_oe_n | p1) & !pull;
	wire logic scl_w = p4_oe_n | p4;
	ecl_config_loader u_ecl_config_loader (.clk(clk), .arst_n(arst_n), .latch_strap(1'b0),
		.cfg(cfg), .cfg_rdata(rdata), .cfg_ack(ack), .legacy_irq_req(lreq), .pci_irq_a_req(ia),
		.pci_irq_b_req(ib), .card_status_change(misc[0]), .ring_in(misc[1]), .speaker_in(misc[2]),
		.other_req(misc[3]), .bus_owned(misc[4]), .card_req(misc[5]), .card_xfer_active(misc[6]),
		.pin_one_in(sda_w), .bus_release(rel), .card_grant_n(gnt_n), .pci_interrupt_line_a_n(pa_n),
		.pci_interrupt_line_b_n(pb_n), .parallel_legacy_irq_lines(lout), .serialized_irq_line(ser),
		.ring_indicate_output_n(ring_n), .speaker_output(spk), .multifunction_pin_one(p1),
		.multifunction_pin_one_oe_n(p1_oe_n), .multifunction_pin_four(p4),
		.multifunction_pin_four_oe_n(p4_oe_n), .pin_role_active(), .load_busy(busy));
	ecl_eeprom_model u_ecl_eeprom_model (.scl(scl_w), .sda(sda_w), .sda_pull(pull));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// One access; expected read data is queued unless refused while loading
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
		logic [3:0] be;
		be = (a == OFS_SYS_CTRL || a == OFS_PIN_ROUTE) ? 4'hF : (a[7] ? 4'h1 : 4'h3);
		@(posedge clk) #1;
		cfg = '{w, !w, a, be, d};
		if (busy === 1'b0) begin
			q_e.push_back(e);
			q_m.push_back(m);
		end
		@(posedge clk) #1;
		cfg = '0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic chkirq(input logic [1:0] md, input logic tie);
		logic [13:0] lg;
		lg = lreq[15:2];
		chk("line a", (md == 2'h3) | !(ia | misc[0] | (tie & ib)), pa_n);
		if (!tie) chk("line b", (md == 2'h3) | !ib, pb_n);
		chk("legacy", (md == 2'h1) ? {lg, 2'b00} : 16'h0, lout);
		chk("serial", (md[1] & |lg) | ((md == 2'h3) & (ia | ib | misc[0])), ser);
		chk("ring", !misc[1], ring_n);
		chk("speaker", misc[2], spk);
		chk("release", misc[3] & misc[4], rel);
		if (misc[5]) chk("grant", 0, gnt_n);
		else if (!misc[6]) chk("grant idle", 1, gnt_n);
	endtask
	task automatic wrap_up;
		if (q_e.size() != 0) chk("pending ack", 0, q_e.size());
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Each acknowledge takes the oldest expectation
	always @(negedge clk) if (ack === 1'b1) begin
		if (q_e.size() == 0) chk("unexpected ack", 0, 1);
		else chk("cfg read", q_e.pop_front(), rdata & q_m.pop_front());
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	initial begin
		#450000;
		chk("watchdog", 0, 1);
		wrap_up;
	end
	// Main sequence
	initial begin
		{arst_n, ia, ib, misc, lreq, cfg} = '0;
		{errors, check_count} = '0;
		r = 32'h1385;
		for (i = 0; i < 22; i++) begin
			r = xs(r);
			ee[i] = r[7:0];
			u_ecl_eeprom_model.mem[i] = r[7:0];
		end
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("load_busy", 1, busy);
		acc(0, OFS_SUBSYS_VEN, 0, 0, 0);
		for (i = 0; i < 80000 && busy !== 1'b0; i++) @(posedge clk);
		#1 chk("load done", 0, busy);
		#1 acc(0, OFS_SUBSYS_VEN, 0, 32'hFFFF, {ee[3], ee[2]});
		acc(0, OFS_SUBSYS, 0, 32'hFFFF, {ee[5], ee[4]});
		acc(0, OFS_COMMAND, 0, 32'h167, {ee[1][7], 1'b0, ee[1][6:5], 2'b0, ee[1][2:0]});
		acc(0, OFS_DEV_CTRL, 0, 32'h4F, ee[19] & 8'h4F);
		acc(0, OFS_SER_CTRL, 0, 32'h8, 32'h8);
		acc(1, OFS_SER_CTRL, 0, 0, 0);
		acc(0, OFS_SER_CTRL, 0, 32'h8, 0);
		acc(1, OFS_SYS_CTRL, 0, 0, 0);
		acc(1, OFS_SUBSYS_VEN, 32'hA5C3, 0, 0);
		acc(0, OFS_SUBSYS_VEN, 0, 32'hFFFF, 32'hA5C3);
		acc(1, OFS_SYS_CTRL, 32'h20, 0, 0);
		acc(1, OFS_SUBSYS_VEN, 32'h0F0F, 0, 0);
		acc(0, OFS_SUBSYS_VEN, 0, 32'hFFFF, 32'hA5C3);
		acc(1, OFS_PIN_ROUTE, 0, 0, 0);
		acc(1, OFS_CARD_CTRL, 32'h82, 0, 0);
		acc(1, OFS_LEGACY_INT, 32'h10, 0, 0);
		for (t = 0; t < 5; t++) begin
			if (t == 4) acc(1, OFS_SYS_CTRL, 32'h2000_0020, 0, 0);
			acc(1, OFS_DEV_CTRL, {t[1:0], 1'b0}, 0, 0);
			for (i = 0; i < 4; i++) begin
				r = xs(r);
				{ia, ib, misc} = r[31:23];
				lreq = r[15:0];
				repeat (3) @(posedge clk);
				#1 chkirq(t[1:0], t == 4);
			end
		end
		wrap_up;
	end
endmodule
`default_nettype wire
